// >>> pkg/see_pkg.sv
// Purpose: constants for the serial eeprom two-wire target
// Assumes: 25 MHz system clock
// Notes: program time counted in system clock cycles
package see_pkg;
	// =========================================================
	// memory geometry
	localparam int MAIN_BYTES = 4096;
	localparam int PAGE_BYTES = 32;
	localparam int SERIAL_BYTES = 16;
	localparam int ADDR_W = 12;
	// =========================================================
	// device address word layout
	localparam logic [3:0] TYPE_MAIN = 4'ha;
	localparam logic [3:0] TYPE_SPECIAL = 4'hb;
	// second-level selection within type 1011 (first word address bits)
	localparam int SEL_LOCK_BIT = 10;
	localparam int SEL_SERIAL_BIT = 11;
	// =========================================================
	// timing
	localparam int CLOCK_HZ = 25000000;
	localparam int PROGRAM_CYCLE_TIME_US = 5000;
	localparam int PROGRAM_CYCLE_CYCLES = PROGRAM_CYCLE_TIME_US * (CLOCK_HZ / 1000000);
	// =========================================================
	// reset values
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic LOCK_RESET = 1'b0;
	typedef enum logic [2:0] {
		SEE_IDLE,
		SEE_DEVADDR,
		SEE_ADDR_HI,
		SEE_ADDR_LO,
		SEE_WRDATA,
		SEE_RDDATA,
		SEE_RDACK
	} see_state_type;
endpackage

// >>> rtl/see_target.sv
// Purpose: two-wire bus target of a 32 Kbit serial eeprom
// Assumes: bus clock and data arrive asynchronously, sampled on clock_in
// Notes: programming cycle modelled as a timer after the stop condition
`timescale 1ns/1ps
module see_target
#(
	parameter int PROGRAM_CYCLES = see_pkg::PROGRAM_CYCLE_CYCLES
)
(
	// clock, reset, enable
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// two-wire bus
	input wire logic bus_clock_in,
	input wire logic bus_data_in,
	output logic bus_data_out,
	output logic bus_data_oe_out,
	// straps and protection
	input wire logic chip_addr_sel_0_in,
	input wire logic chip_addr_sel_1_in,
	input wire logic chip_addr_sel_2_in,
	input wire logic write_control_n_in,
	// status
	output logic programming_out
);
	// =========================================================
	// input synchronisers
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] wc_sync_reg;
	logic [2:0] sel0_reg;
	logic [2:0] sel_sync_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			wc_sync_reg <= 2'h3;
			sel0_reg <= 3'h0;
			sel_sync_reg <= 3'h0;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else if (clk_en_in)
		begin
			scl_sync_reg <= {scl_sync_reg[0], bus_clock_in};
			sda_sync_reg <= {sda_sync_reg[0], bus_data_in};
			wc_sync_reg <= {wc_sync_reg[0], write_control_n_in};
			sel0_reg <= {chip_addr_sel_2_in, chip_addr_sel_1_in, chip_addr_sel_0_in};
			sel_sync_reg <= sel0_reg;
			scl_d_reg <= scl_sync_reg[1];
			sda_d_reg <= sda_sync_reg[1];
		end
	end
	wire scl = scl_sync_reg[1];
	wire sda = sda_sync_reg[1];
	wire scl_rise = scl & ~scl_d_reg;
	wire scl_fall = ~scl & scl_d_reg;
	// data sampled on clock high relies on the master's setup
	wire start_det = scl & scl_d_reg & sda_d_reg & ~sda;
	wire stop_det = scl & scl_d_reg & ~sda_d_reg & sda;
	// =========================================================
	// storage
	logic [7:0] main_mem [0:see_pkg::MAIN_BYTES-1];
	logic [7:0] id_mem [0:see_pkg::PAGE_BYTES-1];
	logic [7:0] serial_rom [0:see_pkg::SERIAL_BYTES-1];
	genvar g;
	generate
		for (g = 0; g < see_pkg::SERIAL_BYTES; g++)
		begin : g_serial
			// serial number content is arbitrary
			assign serial_rom[g] = 8'(8'h5a ^ g);
		end
	endgenerate
	// page write buffer
	logic [7:0] pbuf [0:see_pkg::PAGE_BYTES-1];
	logic [see_pkg::PAGE_BYTES-1:0] pvalid_reg;
	// =========================================================
	// protocol state
	see_pkg::see_state_type state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic acking_reg;
	logic special_reg;
	logic [1:0] area_reg;
	logic [see_pkg::ADDR_W-1:0] addr_reg;
	logic locked_reg;
	logic lock_req_reg;
	logic wr_pending_reg;
	logic [22:0] prog_cnt_reg;
	logic programming_reg;
	logic master_ack_reg;
	logic sda_oe_reg;
	// area codes: 0 main, 1 id page, 2 lock bit, 3 serial
	wire [7:0] rx_byte = {shift_reg[6:0], sda};
	// decoders look at the completed byte, not at the next shift
	wire dev_hit = (shift_reg[3:1] == sel_sync_reg) &&
		(shift_reg[7:4] == see_pkg::TYPE_MAIN || shift_reg[7:4] == see_pkg::TYPE_SPECIAL);
	wire wr_allowed = ~wc_sync_reg[1] &
		(area_reg == 2'd0 || (area_reg == 2'd1 && !locked_reg));
	wire [7:0] rd_byte = (area_reg == 2'd1) ? id_mem[addr_reg[4:0]] :
		(area_reg == 2'd3) ? serial_rom[addr_reg[3:0]] :
		(area_reg == 2'd2) ? {7'h0, locked_reg} : main_mem[addr_reg];
	wire [1:0] area_sel = !special_reg ? 2'd0 :
		shift_reg[see_pkg::SEL_LOCK_BIT-8] ? 2'd2 :
		shift_reg[see_pkg::SEL_SERIAL_BIT-8] ? 2'd3 : 2'd1;
	wire byte_done = scl_fall && bit_cnt_reg == 4'd8 && !acking_reg;
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= see_pkg::SEE_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			acking_reg <= 1'b0;
			special_reg <= 1'b0;
			area_reg <= 2'd0;
			addr_reg <= '0;
			locked_reg <= see_pkg::LOCK_RESET;
			lock_req_reg <= 1'b0;
			wr_pending_reg <= 1'b0;
			pvalid_reg <= '0;
			prog_cnt_reg <= 23'h0;
			programming_reg <= 1'b0;
			master_ack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (programming_reg)
			begin
				// self-timed program cycle
				if (prog_cnt_reg == 23'(PROGRAM_CYCLES - 1))
				begin
					programming_reg <= 1'b0;
					prog_cnt_reg <= 23'h0;
				end
				else
					prog_cnt_reg <= prog_cnt_reg + 23'h1;
			end
			if (start_det)
			begin
				state_reg <= see_pkg::SEE_DEVADDR;
				bit_cnt_reg <= 4'h0;
				acking_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
				wr_pending_reg <= 1'b0;
				pvalid_reg <= '0;
			end
			else if (stop_det)
			begin
				state_reg <= see_pkg::SEE_IDLE;
				sda_oe_reg <= 1'b0;
				if (wr_pending_reg)
				begin
					// commit every buffered byte of the page at once
					for (int i = 0; i < see_pkg::PAGE_BYTES; i++)
						if (pvalid_reg[i] && area_reg == 2'd1)
							id_mem[i] <= pbuf[i];
						else if (pvalid_reg[i])
							main_mem[{addr_reg[see_pkg::ADDR_W-1:5], 5'(i)}] <= pbuf[i];
					if (lock_req_reg)
						locked_reg <= 1'b1;
					programming_reg <= 1'b1;
					prog_cnt_reg <= 23'h0;
				end
				wr_pending_reg <= 1'b0;
				lock_req_reg <= 1'b0;
				pvalid_reg <= '0;
			end
			else if (state_reg != see_pkg::SEE_IDLE)
			begin
				if (scl_rise && !acking_reg && bit_cnt_reg < 4'd8)
				begin
					shift_reg <= rx_byte;
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				if (scl_rise && acking_reg && state_reg == see_pkg::SEE_RDACK)
					master_ack_reg <= ~sda;
				if (scl_fall && acking_reg)
				begin
					// ninth clock over
					acking_reg <= 1'b0;
					bit_cnt_reg <= 4'h0;
					sda_oe_reg <= 1'b0;
					if (state_reg == see_pkg::SEE_RDACK)
					begin
						if (master_ack_reg)
						begin
							// sequential read
							state_reg <= see_pkg::SEE_RDDATA;
							sda_oe_reg <= ~rd_byte[7];
							shift_reg <= rd_byte;
						end
						else
							state_reg <= see_pkg::SEE_IDLE;
					end
					else if (state_reg == see_pkg::SEE_RDDATA)
					begin
						sda_oe_reg <= ~rd_byte[7];
						shift_reg <= rd_byte;
					end
				end
				else if (state_reg == see_pkg::SEE_RDDATA && scl_fall && !acking_reg)
				begin
					if (bit_cnt_reg == 4'd8)
					begin
						acking_reg <= 1'b1;
						sda_oe_reg <= 1'b0;
						state_reg <= see_pkg::SEE_RDACK;
						addr_reg <= addr_reg + 12'h1;
					end
					else
						sda_oe_reg <= ~shift_reg[7]; // the rise already shifted
				end
				else if (byte_done)
				begin
					unique case (state_reg)
						see_pkg::SEE_DEVADDR:
						begin
							if (dev_hit && !programming_reg)
							begin
								acking_reg <= 1'b1;
								sda_oe_reg <= 1'b1;
								special_reg <= shift_reg[4];
								if (shift_reg[0])
									state_reg <= see_pkg::SEE_RDDATA;
								else
									state_reg <= see_pkg::SEE_ADDR_HI;
							end
							else
								state_reg <= see_pkg::SEE_IDLE;
						end
						see_pkg::SEE_ADDR_HI:
						begin
							acking_reg <= 1'b1;
							sda_oe_reg <= 1'b1;
							area_reg <= area_sel;
							addr_reg[see_pkg::ADDR_W-1:8] <= shift_reg[3:0];
							state_reg <= see_pkg::SEE_ADDR_LO;
						end
						see_pkg::SEE_ADDR_LO:
						begin
							acking_reg <= 1'b1;
							sda_oe_reg <= 1'b1;
							addr_reg[7:0] <= shift_reg;
							state_reg <= see_pkg::SEE_WRDATA;
						end
						see_pkg::SEE_WRDATA:
						begin
							if (wr_allowed || (area_reg == 2'd2 && ~wc_sync_reg[1]))
							begin
								acking_reg <= 1'b1;
								sda_oe_reg <= 1'b1;
								wr_pending_reg <= 1'b1;
								if (area_reg == 2'd2)
									lock_req_reg <= 1'b1;
								else
								begin
									pbuf[addr_reg[4:0]] <= shift_reg;
									pvalid_reg[addr_reg[4:0]] <= 1'b1;
								end
								// roll over within the page
								addr_reg[4:0] <= addr_reg[4:0] + 5'h1;
							end
							else
								state_reg <= see_pkg::SEE_IDLE;
						end
						default:
							state_reg <= see_pkg::SEE_IDLE;
					endcase
				end
			end
		end
	end
	assign bus_data_out = 1'b0;
	assign bus_data_oe_out = sda_oe_reg;
	assign programming_out = programming_reg;
endmodule

// >>> test/see_bus_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: bus clock period of 8 system clocks
// Notes: data line is open drain with a pull-up
`timescale 1ns/1ps
module see_bus_master
(
	input wire logic clock_in,
	input wire logic sda_in,
	output logic scl_out = 1'b1,
	output logic sda_oe_out = 1'b0
);
	task automatic hp(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	// data moves only mid low phase
	// bit period fixed at 8 system clocks
	task automatic put(input logic b);
		scl_out = 1'b0;
		hp(2);
		sda_oe_out = !b;
		hp(2);
		scl_out = 1'b1;
		hp(4);
	endtask
	// every command opens with a start
	task automatic start(input logic rep);
		if (rep)
			put(1'b1);
		sda_oe_out = 1'b1;
		hp(4);
	endtask
	task automatic stop();
		put(1'b0);
		sda_oe_out = 1'b0;
		hp(4);
	endtask
	// one byte msb first, then the ninth bit
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			put(tx[i]);
			rx[i] = sda_in;
		end
		put(mack);
		ack = !sda_in;
	endtask
endmodule

// >>> test/see_target_props.sv
// Purpose: pin-level checks of the eeprom two-wire target
// Assumes: bench runs with a short program cycle
// Notes: bound onto see_target
`timescale 1ns/1ps
module see_target_props
#(
	parameter int PROGRAM_CYCLES = 50
)
(
	// clock, reset, enable
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// two-wire bus
	input wire logic bus_clock_in,
	input wire logic bus_data_in,
	input wire logic bus_data_out,
	input wire logic bus_data_oe_out,
	// straps, protection, status
	input wire logic chip_addr_sel_0_in,
	input wire logic chip_addr_sel_1_in,
	input wire logic chip_addr_sel_2_in,
	input wire logic write_control_n_in,
	input wire logic programming_out
);
	int cnt_reg;
	// counts enabled cycles of one program cycle
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cnt_reg <= 0;
		else if (!programming_out)
			cnt_reg <= 0;
		else if (clk_en_in)
			cnt_reg <= cnt_reg + 1;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	property p_open_drain; bus_data_oe_out |-> !bus_data_out; endproperty
	a_open_drain: assert property (p_open_drain) else $error("data driven high");
	property p_ack_hold; $rose(bus_data_oe_out) |-> bus_data_oe_out [*5]; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("low drive too short");
	property p_busy; programming_out |-> !$rose(bus_data_oe_out); endproperty
	a_busy: assert property (p_busy) else $error("answered while busy");
	property p_prog_max; cnt_reg <= PROGRAM_CYCLES + 2; endproperty
	a_prog_max: assert property (p_prog_max) else $error("program too long");
	property p_prog_len; $fell(programming_out) |-> cnt_reg >= PROGRAM_CYCLES - 2; endproperty
	a_prog_len: assert property (p_prog_len) else $error("program too short");
	property p_wp; $rose(programming_out) |-> !$past(write_control_n_in, 8); endproperty
	a_wp: assert property (p_wp) else $error("programmed while protected");
	property p_freeze;
		!clk_en_in |=> $stable(programming_out) && $stable(bus_data_oe_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("moved while frozen");
	property p_rst; $rose(rst_n_in) |-> !bus_data_oe_out && !programming_out; endproperty
	a_rst: assert property (p_rst) else $error("busy out of reset");
endmodule
bind see_target see_target_props #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_props (.*);

// >>> test/see_target_test.sv
// Purpose: self-checking bench of the eeprom two-wire target
// Assumes: straps 101, short program cycle
// Notes: bus driven by see_bus_master
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module see_target_test;
	localparam int PC = 400;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic clk_en_in = 1'b1;
	logic write_control_n = 1'b0;
	logic [2:0] straps = 3'h5;
	logic scl, m_oe, d_out, d_oe, prog, ack;
	logic [7:0] rx;
	wire sda = !(m_oe || d_oe);
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	see_bus_master m (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
	see_target #(.PROGRAM_CYCLES(PC)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in), .bus_clock_in(scl), .bus_data_in(sda), .bus_data_out(d_out),
		.bus_data_oe_out(d_oe), .chip_addr_sel_0_in(straps[0]), .chip_addr_sel_1_in(straps[1]),
		.chip_addr_sel_2_in(straps[2]), .write_control_n_in(write_control_n),
		.programming_out(prog));
	initial
		forever #20 clock_in = ~clock_in;
	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			summarize();
		end
	end
	task automatic wr(input logic [7:0] v);
		m.xfer(v, 1'b1, rx, ack);
	endtask
	task automatic seek(input logic [7:0] dev, input logic [7:0] hi, input logic [7:0] lo);
		m.start(1'b0);
		wr(dev);
		`CHK(ack, 1'b1)
		wr(hi);
		`CHK(ack, 1'b1)
		wr(lo);
		`CHK(ack, 1'b1)
	endtask
	// reads n bytes from the current address, last one not acknowledged
	task automatic rd_check(input logic [7:0] dev, input int n, input logic [7:0] q[$]);
		m.start(1'b1);
		wr(dev);
		`CHK(ack, 1'b1)
		for (int i = 0; i < n; i++)
		begin
			m.xfer(8'hff, i == n - 1, rx, ack);
			`CHK(rx, q[i])
		end
		m.stop();
	endtask
	// 33 bytes from the last offset wrap round one page
	task automatic t_page();
		logic [7:0] q[$];
		seek(8'haa, 8'h00, 8'h3f);
		for (int i = 0; i < 33; i++)
		begin
			wr(8'(8'h10 + i));
			`CHK(ack, 1'b1)
		end
		m.stop();
		m.start(1'b0);
		wr(8'haa);
		`CHK(ack, 1'b0)
		`CHK(prog, 1'b1)
		m.stop();
		clk_en_in = 1'b0;
		repeat (10) @(negedge clock_in);
		clk_en_in = 1'b1;
		repeat (600) if (prog) @(negedge clock_in);
		`CHK(prog, 1'b0)
		for (int i = 0; i < 32; i++)
			q.push_back((i == 31) ? 8'h30 : 8'(8'h11 + i));
		seek(8'haa, 8'h00, 8'h20);
		rd_check(8'hab, 32, q);
	endtask
	task automatic t_protect();
		write_control_n = 1'b1;
		seek(8'haa, 8'h01, 8'h00);
		wr(8'h55);
		`CHK(ack, 1'b0)
		m.stop();
		repeat (20) @(negedge clock_in);
		`CHK(prog, 1'b0)
		write_control_n = 1'b0;
		m.start(1'b0);
		wr(8'ha0);
		`CHK(ack, 1'b0)
		m.stop();
		// straps moved to match: the same word is now answered
		straps = 3'h0;
		m.start(1'b0);
		wr(8'ha0);
		`CHK(ack, 1'b1)
		m.stop();
		straps = 3'h5;
	endtask
	// id page takes data until locked, then refuses it
	task automatic t_lock();
		logic [7:0] q[$];
		q.push_back(8'h3c);
		seek(8'hba, 8'h00, 8'h05);
		wr(8'h3c);
		`CHK(ack, 1'b1)
		m.stop();
		repeat (450) @(negedge clock_in);
		seek(8'hba, 8'h04, 8'h00);
		wr(8'h01);
		`CHK(ack, 1'b1)
		m.stop();
		repeat (450) @(negedge clock_in);
		seek(8'hba, 8'h00, 8'h05);
		wr(8'h77);
		`CHK(ack, 1'b0)
		m.stop();
		seek(8'hba, 8'h00, 8'h05);
		rd_check(8'hbb, 1, q);
	endtask
	task automatic t_serial();
		logic [7:0] q[$];
		for (int i = 0; i < 16; i++)
			q.push_back(8'(8'h5a ^ i));
		seek(8'hba, 8'h08, 8'h00);
		rd_check(8'hbb, 16, q);
	endtask
	initial
	begin
		repeat (20) @(negedge clock_in);
		rst_n_in = 1'b1;
		repeat (5) @(negedge clock_in);
		t_page();
		t_protect();
		t_lock();
		t_serial();
		summarize();
	end
endmodule
